/* File: logic/ppi_top.sv */
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// (RL1) low four pins interrupt and wake
// (RL2) per-pin enable bit, independent writes
// (RL3) per-port mode: edge or edge-level
// (RL4) per-pin polarity: falling/low or rising/high
// (RL5) synchronous detect, deasserted seen first
// (RL6) falling: high then low sample
// (RL7) rising: low then high sample
// (RL8) edge mode: valid edge sets flag
// (RL9) flag and enable raise request
// (RL10) ack clears flag in edge mode
// (RL11) level mode: edge or level sets
// (RL12) level mode ack needs all deasserted
// (RL13) asserted pin keeps flag on ack
// (RL14) disabled pins never set or block
module ppi_top
   import ppi_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire ppi_pins_t       pin_a,
   input  wire ppi_pins_t       pin_b,
   input  wire logic [AW-1:0]   addr,
   input  wire logic [DW-1:0]   wdata,
   input  wire logic            wr_en,
   input  wire logic            rd_en,
   output logic      [DW-1:0]   rdata,
   output logic      [NPORT-1:0] irq_req,
   output logic                 wake_req
);

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [NPORT*NPIN-1:0] sync_q;
   ppi_pins_t             pins     [NPORT];

   ppi_sync ppi_sync_i (
      .clk  (clk),
      .rstn (rstn),
      .d    ({pin_b, pin_a}),
      .q    (sync_q)
   );

   // -----------------------------------------------------------------
   // per port state
   // -----------------------------------------------------------------
   ppi_cfg_s          cfg_r    [NPORT];
   ppi_cfg_s          cfg_nxt  [NPORT];
   ppi_pins_t         edge_vec [NPORT];
   ppi_pins_t         lvl_vec  [NPORT];
   logic [NPORT-1:0]  edge_any;
   logic [NPORT-1:0]  lvl_any;
   logic [NPORT-1:0]  evt;
   logic [NPORT-1:0]  ack;
   logic [NPORT-1:0]  clr_ok;
   logic [NPORT-1:0]  flag_r;
   logic [NPORT-1:0]  flag_nxt;
   logic [NPORT-1:0]  irq_nxt;
   logic              wake_nxt;
   logic [DW-1:0]     rdata_nxt;

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      assign pins[p] = sync_q[p*NPIN +: NPIN];

      ppi_pin_detect ppi_pin_detect_i (
         .clk      (clk),
         .rstn     (rstn),
         .pins     (pins[p]),
         .cfg      (cfg_r[p]),
         .edge_hit (edge_vec[p]),
         .lvl_hit  (lvl_vec[p])
      );

      assign edge_any[p] = |edge_vec[p];
      assign lvl_any[p]  = |lvl_vec[p];
      // level mode also counts a held asserted level
      assign evt[p]      = edge_any[p] | (cfg_r[p].mode & lvl_any[p]);   // RL8 RL11
      assign ack[p]      = wr_en & (addr == SC_OFF[p]) & wdata[SC_ACK_BIT];
      // edge mode clears unconditionally
      assign clr_ok[p]   = ~cfg_r[p].mode | ~lvl_any[p];                 // RL10 RL12 RL13
   end

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         cfg_nxt[p] = cfg_r[p];
         if (wr_en && addr == SC_OFF[p]) begin
            cfg_nxt[p].mode = wdata[SC_MODE_BIT];                        // RL3
            cfg_nxt[p].ie   = wdata[SC_IE_BIT];
         end
         if (wr_en && addr == EN_OFF[p]) begin
            cfg_nxt[p].en = wdata[NPIN-1:0];                             // RL2
         end
         if (wr_en && addr == POL_OFF[p]) begin
            cfg_nxt[p].pol = wdata[NPIN-1:0];                            // RL4
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int p = 0; p < NPORT; p++) begin
            cfg_r[p] <= '{ie: IE_RST, mode: MODE_RST, pol: POL_RST, en: EN_RST};
         end
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            cfg_r[p] <= cfg_nxt[p];
         end
      end
   end

   // -----------------------------------------------------------------
   // port flags
   // -----------------------------------------------------------------
   // a new event wins over an acknowledge in the same cycle
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         flag_nxt[p] = evt[p] | (flag_r[p] & ~(ack[p] & clr_ok[p]));     // RL8 RL10 RL11 RL12 RL13
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         flag_r <= '0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // -----------------------------------------------------------------
   // request and wake outputs
   // -----------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         irq_nxt[p] = flag_r[p] & cfg_r[p].ie;                           // RL9
      end
      // wake from wait or stop3 follows any pending enabled request
      wake_nxt = |irq_nxt;                                               // RL1
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_req  <= '0;
         wake_req <= 1'h0;
      end else begin
         irq_req  <= irq_nxt;
         wake_req <= wake_nxt;
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   // acknowledge reads back as zero; unmapped reads as zero
   always_comb begin
      rdata_nxt = RD_NONE;
      if (rd_en) begin
         for (int p = 0; p < NPORT; p++) begin
            if (addr == SC_OFF[p]) begin
               rdata_nxt[SC_FLAG_BIT] = flag_r[p];
               rdata_nxt[SC_IE_BIT]   = cfg_r[p].ie;
               rdata_nxt[SC_MODE_BIT] = cfg_r[p].mode;
            end
            if (addr == EN_OFF[p]) begin
               rdata_nxt[NPIN-1:0] = cfg_r[p].en;
            end
            if (addr == POL_OFF[p]) begin
               rdata_nxt[NPIN-1:0] = cfg_r[p].pol;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata <= RD_NONE;
      end else begin
         rdata <= rdata_nxt;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   wake_quiet_a: assert property ( // RL1
      !(flag_r[0] && cfg_r[0].ie) && !(flag_r[1] && cfg_r[1].ie) |=> !wake_req)
      else $error("wake without a pending request");

   read_idle_a: assert property (
      !rd_en |=> rdata == RD_NONE)
      else $error("read data outside a read cycle");

   for (genvar p = 0; p < NPORT; p++) begin : g_chk

      // -----------------------------------------------------------------
      // per pin sense and edge checks
      // -----------------------------------------------------------------
      for (genvar i = 0; i < NPIN; i++) begin : g_pin_chk

         fall_edge_a: assert property ( // RL6
            cfg_r[p].en[i] && !cfg_r[p].pol[i] && $stable(cfg_r[p]) &&
            $past(pins[p][i]) && !pins[p][i] |-> edge_vec[p][i])
            else $error("falling edge not detected");

         rise_edge_a: assert property ( // RL7
            cfg_r[p].en[i] && cfg_r[p].pol[i] && $stable(cfg_r[p]) &&
            !$past(pins[p][i]) && pins[p][i] |-> edge_vec[p][i])
            else $error("rising edge not detected");

         arm_first_a: assert property ( // RL5
            !$past(cfg_r[p].en[i]) |-> !edge_vec[p][i])
            else $error("edge seen before pin was armed");

         edge_change_a: assert property ( // RL5
            edge_vec[p][i] && $stable(cfg_r[p].pol[i]) |-> $past(pins[p][i]) != pins[p][i])
            else $error("edge without a pin change");

         lvl_sense_a: assert property ( // RL4
            cfg_r[p].en[i] |-> lvl_vec[p][i] == (pins[p][i] == cfg_r[p].pol[i]))
            else $error("level sense ignores polarity");

         pin_off_a: assert property ( // RL14
            !cfg_r[p].en[i] |-> !edge_vec[p][i] && !lvl_vec[p][i])
            else $error("disabled pin produced an event");
      end

      // -----------------------------------------------------------------
      // flag and request checks
      // -----------------------------------------------------------------
      edge_sets_a: assert property ( // RL8
         edge_any[p] |=> flag_r[p])
         else $error("edge did not set the port flag");

      level_sets_a: assert property ( // RL11
         cfg_r[p].mode && lvl_any[p] |=> flag_r[p])
         else $error("held level did not set the flag");

      edge_mode_lvl_a: assert property ( // RL3
         !cfg_r[p].mode && !edge_any[p] && !flag_r[p] |=> !flag_r[p])
         else $error("level set the flag in edge mode");

      flag_stay_a: assert property ( // RL8
         flag_r[p] && !ack[p] |=> flag_r[p])
         else $error("flag dropped without acknowledge");

      flag_quiet_a: assert property ( // RL14
         !flag_r[p] && !evt[p] |=> !flag_r[p])
         else $error("flag set without an event");

      flag_cause_a: assert property ( // RL8
         $rose(flag_r[p]) |-> $past(evt[p]))
         else $error("flag rose without an event");

      irq_raise_a: assert property ( // RL9
         flag_r[p] && cfg_r[p].ie |=> irq_req[p] ##0 wake_req)
         else $error("request missing for set flag");

      irq_quiet_a: assert property ( // RL9
         !flag_r[p] || !cfg_r[p].ie |=> !irq_req[p])
         else $error("request without flag and enable");

      irq_cause_a: assert property ( // RL9
         $rose(irq_req[p]) |-> $past(flag_r[p]) && $past(cfg_r[p].ie))
         else $error("request rose without flag and enable");

      ack_edge_a: assert property ( // RL10
         ack[p] && !cfg_r[p].mode && !evt[p] |=> !flag_r[p])
         else $error("acknowledge failed in edge mode");

      ack_other_a: assert property ( // RL10
         ack[p] && flag_r[NPORT-1-p] |=> flag_r[NPORT-1-p])
         else $error("acknowledge cleared the other port");

      ack_clear_a: assert property ( // RL12
         ack[p] && cfg_r[p].mode && !lvl_any[p] && !edge_any[p] |=> !flag_r[p])
         else $error("acknowledge failed with pins deasserted");

      ack_hold_a: assert property ( // RL13
         ack[p] && cfg_r[p].mode && lvl_any[p] && flag_r[p] |=> flag_r[p])
         else $error("flag dropped while a pin is asserted");

      clear_cause_a: assert property ( // RL10
         $fell(flag_r[p]) |-> $past(ack[p]) && $past(clr_ok[p]))
         else $error("flag fell without a valid acknowledge");

      // -----------------------------------------------------------------
      // register access checks
      // -----------------------------------------------------------------
      en_write_a: assert property ( // RL2
         wr_en && addr == EN_OFF[p] |=> cfg_r[p].en == $past(wdata[NPIN-1:0]) &&
         $stable(cfg_r[p].pol))
         else $error("enable write not taken");

      en_other_a: assert property ( // RL2
         wr_en && addr == EN_OFF[p] |=> $stable(cfg_r[NPORT-1-p].en))
         else $error("enable write touched the other port");

      pol_write_a: assert property ( // RL4
         wr_en && addr == POL_OFF[p] |=> cfg_r[p].pol == $past(wdata[NPIN-1:0]) &&
         $stable(cfg_r[p].en))
         else $error("polarity write not taken");

      mode_write_a: assert property ( // RL3
         wr_en && addr == SC_OFF[p] |=> cfg_r[p].mode == $past(wdata[SC_MODE_BIT]) &&
         cfg_r[p].ie == $past(wdata[SC_IE_BIT]))
         else $error("status control write not taken");

      en_read_a: assert property ( // RL2
         rd_en && addr == EN_OFF[p] |=>
         rdata[NPIN-1:0] == $past(cfg_r[p].en) && rdata[DW-1:NPIN] == '0)
         else $error("enable read back wrong");

      status_read_a: assert property ( // RL8
         rd_en && addr == SC_OFF[p] |=> rdata[SC_FLAG_BIT] == $past(flag_r[p]) && !rdata[SC_ACK_BIT])
         else $error("status read back wrong");

      // -----------------------------------------------------------------
      // scenarios
      // -----------------------------------------------------------------
      flag_cov_c: cover property (
         !flag_r[p] ##1 edge_any[p] ##1 flag_r[p] ##1 irq_req[p]);

      ack_cov_c: cover property (
         flag_r[p] && ack[p] && clr_ok[p] ##1 !flag_r[p]);

      hold_cov_c: cover property (
         flag_r[p] && ack[p] && !clr_ok[p] ##1 flag_r[p]);

      level_cov_c: cover property (
         cfg_r[p].mode && lvl_any[p] && !edge_any[p] && !flag_r[p] ##1 flag_r[p]);

      rise_cov_c: cover property (
         cfg_r[p].pol[0] && edge_vec[p][0] ##1 flag_r[p]);
   end

endmodule

/* File: logic/ppi_pkg.sv */
package ppi_pkg;

   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int NPORT = 2;
   localparam int NPIN  = 4;
   localparam int DW    = 8;
   localparam int AW    = 8;

   // -----------------------------------------------------------------
   // register offsets (port a, port b)
   // -----------------------------------------------------------------
   localparam logic [AW-1:0] SC_OFF  [NPORT] = '{8'h00, 8'h04};
   localparam logic [AW-1:0] EN_OFF  [NPORT] = '{8'h01, 8'h05};
   localparam logic [AW-1:0] POL_OFF [NPORT] = '{8'h02, 8'h06};

   // -----------------------------------------------------------------
   // status/control field positions
   // -----------------------------------------------------------------
   localparam int SC_MODE_BIT = 0;
   localparam int SC_IE_BIT   = 1;
   localparam int SC_ACK_BIT  = 2;
   localparam int SC_FLAG_BIT = 3;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [NPIN-1:0] EN_RST   = 4'h0;
   localparam logic [NPIN-1:0] POL_RST  = 4'h0;
   localparam logic            MODE_RST = 1'h0;
   localparam logic            IE_RST   = 1'h0;
   localparam logic [DW-1:0]   RD_NONE  = 8'h00;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef logic [NPIN-1:0] ppi_pins_t;

   typedef struct packed {
      logic      ie;
      logic      mode;
      ppi_pins_t pol;
      ppi_pins_t en;
   } ppi_cfg_s;

endpackage

/* File: logic/ppi_sync.sv */
`timescale 1ns/100ps
module ppi_sync
   import ppi_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic [NPORT*NPIN-1:0] d,
   output logic      [NPORT*NPIN-1:0] q
);
   logic [NPORT*NPIN-1:0] s1_r;

   // two flops; s1_r feeds only the second flop
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_r <= '0;
         q    <= '0;
      end else begin
         s1_r <= d;
         q    <= s1_r;
      end
   end
endmodule

/* File: logic/ppi_pin_detect.sv */
`timescale 1ns/100ps
module ppi_pin_detect
   import ppi_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rstn,
   input  wire ppi_pins_t pins,
   input  wire ppi_cfg_s  cfg,
   output ppi_pins_t      edge_hit,
   output ppi_pins_t      lvl_hit
);
   ppi_pins_t act;
   ppi_pins_t armed_r;
   ppi_pins_t armed_nxt;

   // -----------------------------------------------------------------
   // per pin sense
   // -----------------------------------------------------------------
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      assign act[i]    = ~(pins[i] ^ cfg.pol[i]);           // RL4
      assign lvl_hit[i]  = cfg.en[i] & act[i];              // RL14
      assign edge_hit[i] = armed_r[i] & cfg.en[i] & act[i]; // RL6 RL7
   end

   // armed: enabled pin seen deasserted in the previous clock cycle
   always_comb begin
      armed_nxt = cfg.en & ~act;                            // RL5
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         armed_r <= '0;
      end else begin
         armed_r <= armed_nxt;
      end
   end
endmodule

/* File: testbench/ppi_pin_src.sv */
`timescale 1ns/100ps
module ppi_pin_src
   import ppi_pkg::*;
(
   input  wire logic clk,
   output ppi_pins_t pin_a,
   output ppi_pins_t pin_b
);

   // -----------------------------------------------------------------
   // external pin drivers, port a idles high and port b idles low
   // -----------------------------------------------------------------
   initial begin
      pin_a = 4'hf;
      pin_b = 4'h0;
   end

   // pins change just after a clock edge, as a real source would be sampled
   task automatic set_pin(input int p, input int n, input logic v);
      @(posedge clk);
      if (p == 0) begin
         pin_a[n] <= v;
      end
      else begin
         pin_b[n] <= v;
      end
   endtask

endmodule

/* File: testbench/port_pin_interrupt_detect_bench.sv */
`timescale 1ns/100ps
module port_pin_interrupt_detect_bench
   import ppi_pkg::*;
;
   logic             clk;
   logic             rstn;
   ppi_pins_t        pin_a;
   ppi_pins_t        pin_b;
   logic [AW-1:0]    addr;
   logic [DW-1:0]    wdata;
   logic             wr_en;
   logic             rd_en;
   logic [DW-1:0]    rdata;
   logic [NPORT-1:0] irq_req;
   logic             wake_req;
   int               mismatches;
   int               n_tests;
   int               cycles;

   ppi_top ppi_top_i (.clk(clk), .rstn(rstn), .pin_a(pin_a), .pin_b(pin_b), .addr(addr), .wdata(wdata),
                      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq_req(irq_req), .wake_req(wake_req));
   ppi_pin_src ppi_pin_src_i (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

   // -----------------------------------------------------------------
   // clock, timeout and helpers
   // -----------------------------------------------------------------
   always #25 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end
      else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [DW-1:0] e, input logic [DW-1:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'h1;
      @(posedge clk);
      wr_en <= 1'h0;
   endtask

   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'h1;
      @(posedge clk);
      rd_en <= 1'h0;
      #1;
      chk("rdata", e, rdata);
   endtask

   task automatic ckirq(input logic [NPORT-1:0] e);
      chk("irq_req", {6'h00, e}, {6'h00, irq_req});
      chk("wake_req", {7'h00, |e}, {7'h00, wake_req});
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      clk = 1'h0;
      rstn = 1'h0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'h0;
      rd_en = 1'h0;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      wait_n(3);
      rd(SC_OFF[0], 8'h00);
      rd(POL_OFF[1], 8'h00);
      wr(8'h03, 8'hff);
      rd(8'h03, 8'h00);
      // port a: edge only, falling
      ppi_pin_src_i.set_pin(0, 2, 1'h0);
      wr(SC_OFF[0], 8'h02);
      wr(EN_OFF[0], 8'h05);
      rd(EN_OFF[0], 8'h05);
      wait_n(6);
      ckirq(2'h0);
      ppi_pin_src_i.set_pin(0, 1, 1'h0);
      wait_n(6);
      ckirq(2'h0);
      ppi_pin_src_i.set_pin(0, 0, 1'h0);
      wait_n(5);
      ckirq(2'h1);
      rd(SC_OFF[0], 8'h0a);
      wr(SC_OFF[0], 8'h06);
      wait_n(2);
      ckirq(2'h0);
      wr(SC_OFF[0], 8'h00);
      ppi_pin_src_i.set_pin(0, 0, 1'h1);
      ppi_pin_src_i.set_pin(0, 0, 1'h0);
      wait_n(6);
      ckirq(2'h0);
      rd(SC_OFF[0], 8'h08);
      wr(SC_OFF[0], 8'h04);
      // port b: edge and level, rising
      wr(POL_OFF[1], 8'h01);
      wr(EN_OFF[1], 8'h01);
      wr(SC_OFF[1], 8'h03);
      wait_n(6);
      ckirq(2'h0);
      ppi_pin_src_i.set_pin(1, 0, 1'h1);
      wait_n(5);
      ckirq(2'h2);
      rd(SC_OFF[1], 8'h0b);
      wr(SC_OFF[1], 8'h07);
      wait_n(3);
      ckirq(2'h2);
      ppi_pin_src_i.set_pin(1, 0, 1'h0);
      wait_n(4);
      wr(SC_OFF[1], 8'h07);
      wait_n(2);
      ckirq(2'h0);
      wr(EN_OFF[1], 8'h05);
      wait_n(5);
      ckirq(2'h2);
      rd(POL_OFF[1], 8'h01);
      print_verdict();
   end

endmodule
